// *** inc/pirf_pkg.sv ***
// constants, field layout and types of the peripheral interrupt flag block
// How it works
// - every flag sets on its event whatever the enables and global enable
// - flags one bit 7 sets on a parallel port access, held until cleared
// - without the parallel port the parallel port flag reads zero
// - flags one bit 6 sets on conversion done, held until written zero
// - bit 5 read-only, one while receive buffer full, cleared on its read
// - bit 4 read-only, one while transmit buffer empty, cleared on its write
// - bit 3 sets on sync serial one transfer done, cleared by software
// - capture mode: bit 2 sets on a timer-one capture, held until cleared
// - compare mode: bit 2 sets on a timer-one compare match, held
// - pulse-width mode: the capture/compare unit never drives its flag
// - flags one bit 1 sets on timer-two period match, held until cleared
// - flags one bit 0 sets on timer-one overflow, held until cleared
package pirf_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_FLAGS_ONE = 8'h00;
    localparam logic [7:0] ADDR_FLAGS_TWO = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL = 8'h10;
    localparam int BIT_PARALLEL = 7;
    localparam int BIT_CONVERSION = 6;
    localparam int BIT_RX_FULL = 5;
    localparam int BIT_TX_EMPTY = 4;
    localparam int BIT_SYNC_ONE = 3;
    localparam int BIT_CAPCOMP_ONE = 2;
    localparam int BIT_TIMER_TWO = 1;
    localparam int BIT_TIMER_ONE = 0;
    localparam int BIT_OSC_FAIL = 7;
    localparam int BIT_COMPARATOR = 6;
    localparam int BIT_BUS_COLLISION = 3;
    localparam int BIT_CAPCOMP_TWO = 0;
    localparam int BIT_GLOBAL_ENABLE = 7;
    localparam int CC1_MODE_LSB = 0;
    localparam int CC2_MODE_LSB = 2;
    localparam logic [7:0] FLAGS_ONE_RW = 8'hCF;
    localparam logic [7:0] FLAGS_TWO_IMPL = 8'hC9;
    localparam logic [7:0] FLAGS_ONE_RST = 8'h00;
    localparam logic [7:0] FLAGS_TWO_RST = 8'h00;
    localparam logic [15:0] IRQ_STATUS_RST = 16'h0000;
    localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    typedef enum logic [1:0] {
        CC_CAPTURE,
        CC_COMPARE,
        CC_PULSE_WIDTH,
        CC_OFF
    } pirf_ccmode_e;
endpackage

// *** inc/pirf_reg_if.sv ***
// register access carrier between the bus slave and the flag core
`timescale 1ns/1ps
interface pirf_reg_if;
    logic wr_stb;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [1:0] wsel;
    logic [15:0] rdata;
    modport bus_side (
        output wr_stb,
        output addr,
        output wdata,
        output wsel,
        input rdata
    );
    modport core_side (
        input wr_stb,
        input addr,
        input wdata,
        input wsel,
        output rdata
    );
endinterface

// *** src/pirf_wb_slave.sv ***
// classic wishbone slave feeding the flag core register port
`timescale 1ns/1ps
module pirf_wb_slave (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    pirf_reg_if.bus_side reg_port
);
    logic ack_ff;
    logic nxt_ack;
    logic [15:0] dat_ff;
    logic [15:0] nxt_dat;
    logic req;

    // ack follows one cycle after the request so back to back never doubles
    assign req = i_wb_cyc & i_wb_stb & ~ack_ff;
    // write lands on the edge where the master sees ack
    assign reg_port.wr_stb = i_wb_cyc & i_wb_stb & i_wb_we & ack_ff;
    assign reg_port.addr = {i_wb_adr[7:2], 2'b00};
    assign reg_port.wdata = i_wb_dat[15:0];
    assign reg_port.wsel = i_wb_sel[1:0];

    always_comb begin
        nxt_ack = req;
        nxt_dat = dat_ff;
        if (req && !i_wb_we) begin
            nxt_dat = reg_port.rdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_ff <= 1'b0;
            dat_ff <= 16'h0000;
        end else begin
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
        end
    end

    assign o_wb_ack = ack_ff;
    assign o_wb_dat = {16'h0000, dat_ff};
endmodule // pirf_wb_slave

// *** src/pirf_top.sv ***
// peripheral interrupt flag registers with wishbone access and irq output
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pirf_top #(
    parameter bit HAS_PARALLEL_PORT = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_parallel_access,
    input wire logic i_conversion_done,
    input wire logic i_rx_buffer_loaded,
    input wire logic i_rx_buffer_read,
    input wire logic i_tx_buffer_emptied,
    input wire logic i_tx_buffer_write,
    input wire logic i_sync_one_done,
    input wire logic i_capcomp_one_capture,
    input wire logic i_capcomp_one_match,
    input wire logic i_timer_two_match,
    input wire logic i_timer_one_overflow,
    input wire logic i_osc_fail,
    input wire logic i_comparator_change,
    input wire logic i_bus_collision,
    input wire logic i_capcomp_two_capture,
    input wire logic i_capcomp_two_match,
    output logic [7:0] o_flags_one,
    output logic [7:0] o_flags_two,
    output logic o_irq
);
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic nxt_rst_meta;
    logic nxt_rst_sync;
    logic rst_n;

    // a constant one shifts in, so release never depends on the pin level
    always_comb begin
        nxt_rst_meta = 1'b1;
        nxt_rst_sync = rst_meta_ff;
    end

    // reset asserts at once, releases two edges later
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= nxt_rst_meta;
            rst_sync_ff <= nxt_rst_sync;
        end
    end

    assign rst_n = rst_sync_ff;

    pirf_reg_if reg_bus ();

    pirf_wb_slave u_wb_slave (
        .i_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr),
        .i_wb_dat(i_wb_dat),
        .i_wb_sel(i_wb_sel),
        .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack),
        .reg_port(reg_bus.bus_side)
    );

    logic [7:0] flags_one_ff;
    logic [7:0] nxt_flags_one;
    logic [7:0] flags_two_ff;
    logic [7:0] nxt_flags_two;
    logic [15:0] irq_status_ff;
    logic [15:0] nxt_irq_status;
    logic [15:0] irq_mask_ff;
    logic [15:0] nxt_irq_mask;
    logic [7:0] control_ff;
    logic [7:0] nxt_control;

    logic [7:0] set_one;
    logic [7:0] set_two;
    logic [7:0] clr_one;
    logic [7:0] clr_two;
    logic [15:0] status_clr;
    logic [15:0] status_set;
    logic [7:0] impl_one;
    logic wr_lane0;
    logic wr_lane1;
    pirf_pkg::pirf_ccmode_e cc1_mode;
    pirf_pkg::pirf_ccmode_e cc2_mode;
    logic cc1_event;
    logic cc2_event;

    // writes honour byte lanes; an unselected lane keeps its bits
    assign wr_lane0 = reg_bus.wr_stb & reg_bus.wsel[0];
    assign wr_lane1 = reg_bus.wr_stb & reg_bus.wsel[1];

    // the parallel port flag simply does not exist on small packages
    assign impl_one = HAS_PARALLEL_PORT ? 8'hFF : 8'h7F;

    assign cc1_mode = pirf_pkg::pirf_ccmode_e'(
        control_ff[pirf_pkg::CC1_MODE_LSB +: 2]);
    assign cc2_mode = pirf_pkg::pirf_ccmode_e'(
        control_ff[pirf_pkg::CC2_MODE_LSB +: 2]);

    // capture/compare sources are picked by mode; pulse width drives nothing
    always_comb begin
        cc1_event = 1'b0;
        unique case (cc1_mode)
            pirf_pkg::CC_CAPTURE: begin
                cc1_event = i_capcomp_one_capture;
            end
            pirf_pkg::CC_COMPARE: begin
                cc1_event = i_capcomp_one_match;
            end
            pirf_pkg::CC_PULSE_WIDTH: begin
                cc1_event = 1'b0;
            end
            pirf_pkg::CC_OFF: begin
                cc1_event = 1'b0;
            end
        endcase
    end

    // second unit decodes its own mode field the same way
    always_comb begin
        cc2_event = 1'b0;
        unique case (cc2_mode)
            pirf_pkg::CC_CAPTURE: begin
                cc2_event = i_capcomp_two_capture;
            end
            pirf_pkg::CC_COMPARE: begin
                cc2_event = i_capcomp_two_match;
            end
            pirf_pkg::CC_PULSE_WIDTH: begin
                cc2_event = 1'b0;
            end
            pirf_pkg::CC_OFF: begin
                cc2_event = 1'b0;
            end
        endcase
    end

    // set terms never look at mask or global enable
    always_comb begin
        set_one = 8'h00;
        set_one[pirf_pkg::BIT_PARALLEL] = i_parallel_access;
        set_one[pirf_pkg::BIT_CONVERSION] = i_conversion_done;
        set_one[pirf_pkg::BIT_RX_FULL] = i_rx_buffer_loaded;
        set_one[pirf_pkg::BIT_TX_EMPTY] = i_tx_buffer_emptied;
        set_one[pirf_pkg::BIT_SYNC_ONE] = i_sync_one_done;
        set_one[pirf_pkg::BIT_CAPCOMP_ONE] = cc1_event;
        set_one[pirf_pkg::BIT_TIMER_TWO] = i_timer_two_match;
        set_one[pirf_pkg::BIT_TIMER_ONE] = i_timer_one_overflow;
        set_one = set_one & impl_one;
    end

    always_comb begin
        set_two = 8'h00;
        set_two[pirf_pkg::BIT_OSC_FAIL] = i_osc_fail;
        set_two[pirf_pkg::BIT_COMPARATOR] = i_comparator_change;
        set_two[pirf_pkg::BIT_BUS_COLLISION] = i_bus_collision;
        set_two[pirf_pkg::BIT_CAPCOMP_TWO] = cc2_event;
        set_two = set_two & pirf_pkg::FLAGS_TWO_IMPL;
    end

    // a write of zero clears a writable flag; a write of one leaves it
    always_comb begin
        clr_one = 8'h00;
        if (wr_lane0 && reg_bus.addr == pirf_pkg::ADDR_FLAGS_ONE) begin
            clr_one = ~reg_bus.wdata[7:0] & pirf_pkg::FLAGS_ONE_RW;
        end
        // buffer flags follow the serial unit, not register writes
        clr_one[pirf_pkg::BIT_RX_FULL] = i_rx_buffer_read;
        clr_one[pirf_pkg::BIT_TX_EMPTY] = i_tx_buffer_write;
    end

    always_comb begin
        clr_two = 8'h00;
        if (wr_lane0 && reg_bus.addr == pirf_pkg::ADDR_FLAGS_TWO) begin
            clr_two = ~reg_bus.wdata[7:0] & pirf_pkg::FLAGS_TWO_IMPL;
        end
    end

    // set wins over a clear in the same cycle so no event is lost
    always_comb begin
        nxt_flags_one = ((flags_one_ff & ~clr_one) | set_one) & impl_one;
        nxt_flags_two = ((flags_two_ff & ~clr_two) | set_two)
            & pirf_pkg::FLAGS_TWO_IMPL;
    end

    // flags reset only through the synchronised reset, never the raw pin
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_one_ff <= pirf_pkg::FLAGS_ONE_RST;
            flags_two_ff <= pirf_pkg::FLAGS_TWO_RST;
        end else begin
            flags_one_ff <= nxt_flags_one;
            flags_two_ff <= nxt_flags_two;
        end
    end

    assign status_set = {set_two, set_one};

    // sticky status copy, one-to-clear, lets software ack irqs without
    // disturbing the flag registers that peripherals also clear
    always_comb begin
        status_clr = 16'h0000;
        if (reg_bus.wr_stb && reg_bus.addr == pirf_pkg::ADDR_IRQ_STATUS) begin
            status_clr[7:0] = reg_bus.wsel[0] ? reg_bus.wdata[7:0] : 8'h00;
            status_clr[15:8] = reg_bus.wsel[1] ? reg_bus.wdata[15:8] : 8'h00;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_status
            always_comb begin
                nxt_irq_status[gi] = status_set[gi]
                    | (irq_status_ff[gi] & ~status_clr[gi]);
            end
        end
    endgenerate

    // mask uses both lanes; control sits in the low lane only
    always_comb begin
        nxt_irq_mask = irq_mask_ff;
        nxt_control = control_ff;
        if (reg_bus.addr == pirf_pkg::ADDR_IRQ_MASK) begin
            if (wr_lane0) begin
                nxt_irq_mask[7:0] = reg_bus.wdata[7:0];
            end
            if (wr_lane1) begin
                nxt_irq_mask[15:8] = reg_bus.wdata[15:8];
            end
        end
        if (wr_lane0 && reg_bus.addr == pirf_pkg::ADDR_CONTROL) begin
            nxt_control = reg_bus.wdata[7:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_ff <= pirf_pkg::IRQ_STATUS_RST;
        end else begin
            irq_status_ff <= nxt_irq_status;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_ff <= pirf_pkg::IRQ_MASK_RST;
            control_ff <= pirf_pkg::CONTROL_RST;
        end else begin
            irq_mask_ff <= nxt_irq_mask;
            control_ff <= nxt_control;
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        reg_bus.rdata = 16'h0000;
        unique case (reg_bus.addr)
            pirf_pkg::ADDR_FLAGS_ONE: begin
                reg_bus.rdata = {8'h00, flags_one_ff};
            end
            pirf_pkg::ADDR_FLAGS_TWO: begin
                reg_bus.rdata = {8'h00, flags_two_ff};
            end
            pirf_pkg::ADDR_IRQ_STATUS: begin
                reg_bus.rdata = irq_status_ff;
            end
            pirf_pkg::ADDR_IRQ_MASK: begin
                reg_bus.rdata = irq_mask_ff;
            end
            pirf_pkg::ADDR_CONTROL: begin
                reg_bus.rdata = {8'h00, control_ff};
            end
            default: begin
                reg_bus.rdata = 16'h0000;
            end
        endcase
    end

    assign o_flags_one = flags_one_ff;
    assign o_flags_two = flags_two_ff;
    // a pending irq stays up until its status bit is written one or its mask bit or the global enable is cleared
    // global enable gates only the output, never the flags
    assign o_irq = control_ff[pirf_pkg::BIT_GLOBAL_ENABLE]
        & (|(irq_status_ff & irq_mask_ff));
endmodule // pirf_top

// *** testbench/pirf_monitor.sv ***
// concurrent checks on the flag block top-level ports
`timescale 1ns/1ps
module pirf_monitor #(
    parameter bit HAS_PARALLEL_PORT = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic o_wb_ack,
    input wire logic i_parallel_access,
    input wire logic i_conversion_done,
    input wire logic i_rx_buffer_loaded,
    input wire logic i_rx_buffer_read,
    input wire logic i_tx_buffer_emptied,
    input wire logic i_tx_buffer_write,
    input wire logic i_timer_one_overflow,
    input wire logic i_osc_fail,
    input wire logic [7:0] o_flags_one,
    input wire logic [7:0] o_flags_two,
    input wire logic o_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    a_parallel_set: assert property (i_parallel_access |=>
        o_flags_one[7] == HAS_PARALLEL_PORT) else $error("parallel flag");
    a_conv_set: assert property (i_conversion_done |=>
        o_flags_one[6]) else $error("conversion flag not set");
    a_rx_set: assert property (i_rx_buffer_loaded |=>
        o_flags_one[5]) else $error("rx flag not set");
    a_rx_clear: assert property (i_rx_buffer_read &&
        !i_rx_buffer_loaded |=> !o_flags_one[5]) else $error("rx flag held");
    a_tx_track: assert property (i_tx_buffer_emptied |=>
        o_flags_one[4] ##1 ($past(i_tx_buffer_write) || o_flags_one[4]))
        else $error("tx flag wrong");
    a_tx_clear: assert property (i_tx_buffer_write &&
        !i_tx_buffer_emptied |=> !o_flags_one[4]) else $error("tx flag held");
    a_timer_hold: assert property ($fell(o_flags_one[0]) |->
        $past(i_wb_cyc && i_wb_stb && i_wb_we && i_wb_adr[7:2] == 6'h00))
        else $error("timer flag dropped without write");
    a_osc_set: assert property (i_osc_fail |=>
        o_flags_two[7]) else $error("osc fail flag not set");
    a_two_unused: assert property ((o_flags_two &
        ~pirf_pkg::FLAGS_TWO_IMPL) == 8'h00) else $error("flags two bit");
    a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
        |=> o_wb_ack ##1 !o_wb_ack) else $error("bus answer wrong");
    c_write: cover property (o_wb_ack && i_wb_we);
    c_irq: cover property ($rose(o_irq));
    c_rx_clear: cover property (i_rx_buffer_read ##1 !o_flags_one[5]);
endmodule // pirf_monitor
bind pirf_top pirf_monitor #(.HAS_PARALLEL_PORT(HAS_PARALLEL_PORT)) u_mon (.*);

// *** testbench/pirf_event_src.sv ***
// peripheral event source model: one-shot pulse per request rise
`timescale 1ns/1ps
module pirf_event_src (
    input wire logic i_clk,
    input wire logic [15:0] i_req,
    output logic [15:0] o_pulse
);
    logic [15:0] req_ff = 16'h0000;
    // edge detect so a long request still gives a single event
    always_comb begin
        o_pulse = i_req & ~req_ff;
    end
    always @(posedge i_clk) begin
        req_ff <= i_req;
    end
endmodule // pirf_event_src

// *** testbench/pirf_top_tb.sv ***
// self-checking bench for the peripheral interrupt flag block
`timescale 1ns/1ps
module pirf_top_tb;
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic [7:0] i_wb_adr = 8'h00;
    logic [31:0] i_wb_dat = 32'h00000000;
    logic [3:0] i_wb_sel = 4'h0;
    logic [31:0] o_wb_dat, rd;
    logic o_wb_ack, o_irq;
    logic [7:0] o_flags_one, o_flags_two;
    logic [7:0] small_flags_one;
    logic [15:0] req = 16'h0000;
    logic [15:0] pulse;
    logic i_parallel_access, i_conversion_done, i_rx_buffer_loaded,
        i_rx_buffer_read, i_tx_buffer_emptied, i_tx_buffer_write,
        i_sync_one_done, i_capcomp_one_capture, i_capcomp_one_match,
        i_timer_two_match, i_timer_one_overflow, i_osc_fail,
        i_comparator_change, i_bus_collision, i_capcomp_two_capture,
        i_capcomp_two_match;
    int n_errors = 0, checked = 0, n_cyc = 0;
    // rows: event index, expected flags one, expected flags two
    logic [19:0] rows [14] = '{20'hF8000, 20'hE4000, 20'hD2000, 20'hB1000,
        20'h90800, 20'h80400, 20'h70000, 20'h60200, 20'h50100, 20'h40080,
        20'h30040, 20'h20008, 20'h10001, 20'h00000};
    assign {i_parallel_access, i_conversion_done, i_rx_buffer_loaded,
        i_rx_buffer_read, i_tx_buffer_emptied, i_tx_buffer_write,
        i_sync_one_done, i_capcomp_one_capture, i_capcomp_one_match,
        i_timer_two_match, i_timer_one_overflow, i_osc_fail,
        i_comparator_change, i_bus_collision, i_capcomp_two_capture,
        i_capcomp_two_match} = pulse;
    pirf_event_src src (.i_clk(i_core_clk), .i_req(req), .o_pulse(pulse));
    pirf_top dut (.*);
    // small package variant: the parallel port flag must never show
    pirf_top #(.HAS_PARALLEL_PORT(1'b0)) dut_small (.*, .o_wb_dat(),
        .o_wb_ack(), .o_flags_one(small_flags_one), .o_flags_two(),
        .o_irq());
    always #4 i_core_clk = ~i_core_clk;
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        n_cyc++;
        if (n_cyc == 3000) begin
            n_errors++;
            $display("CHECK FAILED %0t run too long", $time);
            report_and_stop;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // classic cycle; one idle edge after so the write has landed
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge i_core_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= a;
        i_wb_dat <= {16'h0000, d};
        i_wb_sel <= 4'hF;
        do @(posedge i_core_clk); while (o_wb_ack !== 1'b1);
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 16'h0000);
        chk(rd, exp);
    endtask
    task automatic fire(input int e);
        @(posedge i_core_clk);
        req[e] <= 1'b1;
        @(posedge i_core_clk);
        req <= 16'h0000;
        repeat (2) @(posedge i_core_clk);
    endtask
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        rdchk(8'h00, 32'h00000000);
        rdchk(8'h04, 32'h00000000);
        rdchk(8'h08, 32'h00000000);
        rdchk(8'h0C, 32'h00000000);
        rdchk(8'h10, 32'h00000000);
        chk(o_irq, 32'h0);
        // enables all off here, so each flag must still rise
        for (int i = 0; i < 14; i++) begin
            fire(rows[i][19:16]);
            chk({o_flags_two, o_flags_one},
                {rows[i][7:0], rows[i][15:8]});
            chk(small_flags_one, rows[i][15:8] & 8'h7F);
            rdchk(8'h00, {24'h0, rows[i][15:8]});
            fire(12);
            fire(10);
            wb(1'b1, 8'h00, 16'h0000);
            wb(1'b1, 8'h04, 16'h0000);
            chk({o_flags_two, o_flags_one}, 32'h0);
        end
        // status keeps every event of the loop, masked or not
        rdchk(8'h08, 32'h0000C9FF);
        fire(5);
        fire(6);
        wb(1'b1, 8'h00, 16'h00FE);
        wb(1'b1, 8'h00, 16'h00FF);
        chk(o_flags_one, 32'h02);
        wb(1'b1, 8'h00, 16'h0000);
        wb(1'b1, 8'h08, 16'hFFFF);
        wb(1'b1, 8'h0C, 16'h0001);
        wb(1'b1, 8'h10, 16'h0080);
        chk(o_irq, 32'h0);
        fire(5);
        chk(o_irq, 32'h1);
        wb(1'b1, 8'h0C, 16'h0000);
        chk(o_irq, 32'h0);
        wb(1'b1, 8'h0C, 16'h0001);
        chk(o_irq, 32'h1);
        wb(1'b1, 8'h08, 16'h0001);
        chk(o_irq, 32'h0);
        rdchk(8'h00, 32'h01);
        wb(1'b1, 8'h00, 16'h0000);
        wb(1'b1, 8'h10, 16'h0001);
        // global enable off: flag and status rise, output stays low
        fire(5);
        chk(o_flags_one, 32'h01);
        chk(o_irq, 32'h0);
        wb(1'b1, 8'h00, 16'h0000);
        fire(7);
        chk(o_flags_one, 32'h04);
        wb(1'b1, 8'h00, 16'h0000);
        wb(1'b1, 8'h10, 16'h0002);
        fire(7);
        fire(8);
        chk(o_flags_one, 32'h00);
        rdchk(8'h10, 32'h02);
        // first unit off, second unit in compare mode
        wb(1'b1, 8'h10, 16'h0007);
        fire(7);
        fire(1);
        chk({o_flags_two, o_flags_one}, 32'h0);
        fire(0);
        chk(o_flags_two, 32'h01);
        wb(1'b1, 8'h04, 16'h0000);
        wb(1'b1, 8'h10, 16'h0008);
        fire(0);
        fire(1);
        chk(o_flags_two, 32'h00);
        wb(1'b1, 8'h10, 16'h000C);
        fire(0);
        fire(1);
        fire(8);
        chk({o_flags_two, o_flags_one}, 32'h04);
        wb(1'b1, 8'h20, 16'hFFFF);
        rdchk(8'h20, 32'h00000000);
        // mid-run reset must drop flags, mask, read data and pending irq
        wb(1'b1, 8'h0C, 16'hFFFF);
        wb(1'b1, 8'h10, 16'h0080);
        chk(o_irq, 32'h1);
        rdchk(8'h0C, 32'h0000FFFF);
        @(posedge i_core_clk);
        i_reset_n <= 1'b0;
        @(posedge i_core_clk);
        chk({o_irq, o_wb_ack, o_flags_two, o_flags_one}, 32'h0);
        chk(o_wb_dat, 32'h0);
        repeat (6) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        rdchk(8'h0C, 32'h00000000);
        rdchk(8'h10, 32'h00000000);
        rdchk(8'h08, 32'h00000000);
        report_and_stop;
    end
endmodule // pirf_top_tb
